// *** logic/mio_pkg.sv ***
// constants for the motion io port block
// assumes a single 100 MHz clock domain
package mio_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 2;
  localparam int FUNC_W = 3;
  // input function codes
  localparam logic [2:0] FN_USER = 3'h0;
  localparam logic [2:0] FN_HOME = 3'h1;
  localparam logic [2:0] FN_GO = 3'h2;
  localparam logic [2:0] FN_STOP = 3'h3;
  localparam logic [2:0] FN_JOG_POS = 3'h4;
  localparam logic [2:0] FN_JOG_NEG = 3'h5;
  localparam logic [2:0] FN_LIM_POS = 3'h6;
  localparam logic [2:0] FN_LIM_NEG = 3'h7;
  // register offsets
  localparam logic [3:0] REG_FUNC = 4'h0;
  localparam logic [3:0] REG_IN_RAW = 4'h1;
  localparam logic [3:0] REG_OUT = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_PROG = 4'h4;
  // field positions
  localparam int FUNC_FIELD_W = 3;
  localparam int ST_RUN = 0;
  localparam int ST_STOP = 1;
  localparam int ST_JOG_P = 2;
  localparam int ST_JOG_N = 3;
  localparam int ST_LIM_P = 4;
  localparam int ST_LIM_N = 5;
  localparam int ST_HOME = 6;
  localparam int PROG_CMD_RUN = 0;
  localparam int PROG_CMD_END = 1;
  localparam int PROG_CMD_OUTRD = 2;
  // reset values
  localparam logic [11:0] FUNC_RST = 12'h000;
  localparam logic [1:0] OUT_RST = 2'h0;
  localparam logic [11:0] START_ADDR = 12'h000;
endpackage : mio_pkg

// *** logic/mio_port.sv ***
// input/output port logic of a stepper driver: four inputs with eight input functions, two outputs
// assumes pins arrive asynchronous; motion engine and sequencer sit on this clock
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module mio_port #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [mio_pkg::NUM_IN-1:0] input_pins_n_i,
  output logic [mio_pkg::NUM_OUT-1:0] out_pins_o,
  output logic [mio_pkg::NUM_OUT-1:0] out_pins_oe_n_o,
  input wire logic prog_done_i,
  input wire logic prog_out_wr_i,
  input wire logic [mio_pkg::NUM_OUT-1:0] prog_out_data_i,
  input wire logic move_req_pos_i,
  input wire logic move_req_neg_i,
  output logic [mio_pkg::NUM_IN-1:0] branch_inputs_o,
  output logic prog_start_o,
  output logic [11:0] prog_start_addr_o,
  output logic prog_abort_o,
  output logic prog_running_o,
  output logic decel_stop_o,
  output logic jog_pos_o,
  output logic jog_neg_o,
  output logic motion_abort_o,
  output logic move_pos_allow_o,
  output logic move_neg_allow_o,
  output logic home_switch_o
);

  localparam int NI = mio_pkg::NUM_IN;
  localparam int NO = mio_pkg::NUM_OUT;

  typedef struct packed {
    logic [NI-1:0] sync1;
    logic [NI-1:0] sync2;
    logic [NI-1:0] sync3;
    logic [NI-1:0] act;
    logic [NI*3-1:0] func;
    logic [NO-1:0] outs;
    logic run;
    logic go_prev;
    logic start;
    logic [31:0] rdata;
  } mio_state_s;

  mio_state_s st;
  mio_state_s next_st;

  // true when any input with the given function is active
  function automatic logic mio_func_active(input logic [NI*3-1:0] fn,
                                           input logic [NI-1:0] act,
                                           input logic [2:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NI; i++) begin
      if (fn[i*3 +: 3] == code && act[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : mio_func_active

  logic stop_act;
  logic jog_p_act;
  logic jog_n_act;
  logic lim_p_act;
  logic lim_n_act;
  logic home_act;
  logic go_act;

  always_comb begin
    stop_act = mio_func_active(st.func, st.act, mio_pkg::FN_STOP);
    jog_p_act = mio_func_active(st.func, st.act, mio_pkg::FN_JOG_POS);
    jog_n_act = mio_func_active(st.func, st.act, mio_pkg::FN_JOG_NEG);
    lim_p_act = mio_func_active(st.func, st.act, mio_pkg::FN_LIM_POS);
    lim_n_act = mio_func_active(st.func, st.act, mio_pkg::FN_LIM_NEG);
    home_act = mio_func_active(st.func, st.act, mio_pkg::FN_HOME);
    go_act = mio_func_active(st.func, st.act, mio_pkg::FN_GO);
  end

  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // three-stage sampler; change accepted once stages two and three agree
    next_st.sync1 = ~input_pins_n_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < NI; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.act[i] = st.sync3[i];
      end
    end
    // go only acts on a rising edge and only outside program mode
    next_st.go_prev = go_act;
    if (go_act && !st.go_prev && !st.run) begin
      next_st.run = 1'b1;
      next_st.start = 1'b1;
    end
    if (st.run && (prog_done_i || stop_act || jog_p_act || jog_n_act)) begin
      next_st.run = 1'b0;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        mio_pkg::REG_FUNC: next_st.func = reg_wdata_i[NI*3-1:0];
        mio_pkg::REG_OUT: next_st.outs = reg_wdata_i[NO-1:0];
        mio_pkg::REG_PROG: begin
          if (reg_wdata_i[mio_pkg::PROG_CMD_RUN] && !st.run) begin
            next_st.run = 1'b1;
            next_st.start = 1'b1;
          end
          if (reg_wdata_i[mio_pkg::PROG_CMD_END]) begin
            next_st.run = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // program sequencer writes outputs only in program mode
    if (prog_out_wr_i && st.run) begin
      next_st.outs = prog_out_data_i;
    end
    next_st.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        mio_pkg::REG_FUNC: next_st.rdata[NI*3-1:0] = st.func;
        mio_pkg::REG_IN_RAW: next_st.rdata[NI-1:0] = st.act;
        mio_pkg::REG_OUT: begin
          // readback refused while a program runs; reads zero then
          if (!st.run) begin
            next_st.rdata[NO-1:0] = st.outs;
          end
        end
        mio_pkg::REG_STATUS: begin
          next_st.rdata[mio_pkg::ST_RUN] = st.run;
          next_st.rdata[mio_pkg::ST_STOP] = stop_act;
          next_st.rdata[mio_pkg::ST_JOG_P] = jog_p_act;
          next_st.rdata[mio_pkg::ST_JOG_N] = jog_n_act;
          next_st.rdata[mio_pkg::ST_LIM_P] = lim_p_act;
          next_st.rdata[mio_pkg::ST_LIM_N] = lim_n_act;
          next_st.rdata[mio_pkg::ST_HOME] = home_act;
        end
        mio_pkg::REG_PROG: next_st.rdata[mio_pkg::PROG_CMD_RUN] = st.run;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st.sync1 <= '0;
      st.sync2 <= '0;
      st.sync3 <= '0;
      st.act <= '0;
      st.func <= mio_pkg::FUNC_RST;
      st.outs <= mio_pkg::OUT_RST;
      st.run <= 1'b0;
      // go held at reset must not start a program at once
      st.go_prev <= 1'b1;
      st.start <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  // open collector: drive low when bit is one, otherwise release
  assign out_pins_o = '0;
  assign out_pins_oe_n_o = ~st.outs;
  assign branch_inputs_o = st.act;
  assign prog_start_o = st.start;
  assign prog_start_addr_o = mio_pkg::START_ADDR;
  assign prog_running_o = st.run;
  assign prog_abort_o = st.run && (stop_act || jog_p_act || jog_n_act);
  assign decel_stop_o = stop_act;
  // stop overrides jog so the decelerated halt is never fought
  assign jog_pos_o = jog_p_act && !stop_act && !lim_p_act;
  assign jog_neg_o = jog_n_act && !stop_act && !lim_n_act;
  assign motion_abort_o = jog_p_act || jog_n_act;
  assign move_pos_allow_o = !lim_p_act && !(move_req_pos_i && stop_act);
  assign move_neg_allow_o = !lim_n_act && !(move_req_neg_i && stop_act);
  assign home_switch_o = home_act;

endmodule : mio_port

// *** verif/mio_switches.sv ***
// switch and load model on the io pins
// assumes closed_i high means contact to ground
`timescale 1ns/1ns
module mio_switches (
  input wire logic [3:0] closed_i,
  input wire logic [1:0] oe_n_i,
  output logic [3:0] pins_n_o,
  output logic [1:0] load_o
);
  assign pins_n_o = ~closed_i;
  // released output reads the pull-up level
  assign load_o = oe_n_i;
endmodule : mio_switches

// *** verif/mio_port_props.sv ***
// concurrent checks on the io port block
// assumes a bind onto mio_port, one clock
`timescale 1ns/1ns
module mio_port_props #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [1:0] out_pins_o,
  input wire logic [1:0] out_pins_oe_n_o,
  input wire logic prog_start_o,
  input wire logic [11:0] prog_start_addr_o,
  input wire logic prog_running_o,
  input wire logic prog_abort_o,
  input wire logic decel_stop_o,
  input wire logic jog_pos_o,
  input wire logic motion_abort_o,
  input wire logic move_pos_allow_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence start_pulse;
    prog_start_o ##1 !prog_start_o;
  endsequence
  od_low_a: assert property (out_pins_o == 2'h0) else $error("pin driven");
  start_once_a: assert property (prog_start_o |-> start_pulse) else $error("long start");
  start_addr_a: assert property (prog_start_o |-> prog_start_addr_o == 12'h000)
    else $error("start address");
  go_ignore_a: assert property ($past(prog_running_o) |-> !prog_start_o)
    else $error("start while running");
  stop_end_a: assert property (prog_running_o && decel_stop_o |-> prog_abort_o ##1
    !prog_running_o) else $error("stop kept program");
  jog_abort_a: assert property (jog_pos_o |-> motion_abort_o && move_pos_allow_o)
    else $error("jog without abort");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("stray read data");
  out_wr_a: assert property (reg_wr_i && reg_addr_i == mio_pkg::REG_OUT |=>
    out_pins_oe_n_o == ~$past(reg_wdata_i[1:0])) else $error("output write");
endmodule : mio_port_props
bind mio_port mio_port_props #(.ADDR_W(ADDR_W)) i_props (.*);

// *** verif/test_motion_io_port_logic.sv ***
// self-checking bench for the io port block
// drives sequencer and motion engine through bench stand-ins
`timescale 1ns/1ns
module test_motion_io_port_logic;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] closed = 4'h0;
  // sequencer and motion engine stand-ins
  logic done = 1'b0;
  logic pwr = 1'b0;
  logic mvp = 1'b0;
  logic [1:0] pdat = 2'h0;
  logic [31:0] rdata;
  logic [3:0] pins_n, branch;
  logic [1:0] oe_n, load, opin;
  logic start, run, abort, stop, jp, jn, mab, pa, na, home;
  logic [11:0] saddr;
  int mismatches = 0;
  int n_tests = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  mio_switches i_sw (.closed_i(closed), .oe_n_i(oe_n), .pins_n_o(pins_n), .load_o(load));
  mio_port i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .input_pins_n_i(pins_n), .out_pins_o(opin), .out_pins_oe_n_o(oe_n), .prog_done_i(done),
    .prog_out_wr_i(pwr), .prog_out_data_i(pdat), .move_req_pos_i(mvp),
    .move_req_neg_i(1'b0), .branch_inputs_o(branch), .prog_start_o(start),
    .prog_start_addr_o(saddr), .prog_abort_o(abort), .prog_running_o(run),
    .decel_stop_o(stop), .jog_pos_o(jp), .jog_neg_o(jn), .motion_abort_o(mab),
    .move_pos_allow_o(pa), .move_neg_allow_o(na), .home_switch_o(home));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
  endtask : acc
  task rd(input logic [3:0] a, input logic [31:0] exp);
    acc(a, 32'h0, 1'b0);
    chk(rdata, exp);
  endtask : rd
  // pins pass a synchroniser, so give them time to settle
  task sw(input logic [3:0] v);
    @(posedge clk_sys_i);
    closed <= v;
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask : sw
  // one-cycle pulse of {done, output write, output data} from the sequencer
  task seq(input logic [3:0] v);
    @(posedge clk_sys_i);
    {done, pwr, pdat} <= v;
    @(posedge clk_sys_i);
    {done, pwr, pdat} <= 4'h0;
    #1;
  endtask : seq
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(mio_pkg::REG_FUNC, 32'h0);
    rd(4'hf, 32'h0);
    chk(load, 32'h3);
    $display("test reset done");
    acc(mio_pkg::REG_FUNC, 32'h07e, 1'b1);
    sw(4'h5);
    rd(mio_pkg::REG_IN_RAW, 32'h5);
    chk(branch, 32'h5);
    chk({home, pa, na}, 32'h5);
    sw(4'h2);
    chk({pa, na}, 32'h2);
    $display("test raw done");
    acc(mio_pkg::REG_FUNC, 32'hb1a, 1'b1);
    sw(4'h1);
    chk(run, 32'h1);
    rd(mio_pkg::REG_OUT, 32'h0);
    acc(mio_pkg::REG_OUT, 32'h3, 1'b1);
    chk(load, 32'h0);
    sw(4'h0);
    sw(4'h1);
    chk(run, 32'h1);
    sw(4'h3);
    chk({stop, run}, 32'h2);
    sw(4'h0);
    sw(4'h1);
    sw(4'h5);
    chk({jp, mab, run}, 32'h6);
    sw(4'h9);
    chk({jn, run}, 32'h2);
    rd(mio_pkg::REG_OUT, 32'h3);
    acc(mio_pkg::REG_OUT, 32'h1, 1'b1);
    chk(load, 32'h2);
    $display("test program done");
    sw(4'h0);
    acc(mio_pkg::REG_PROG, 32'h1, 1'b1);
    rd(mio_pkg::REG_STATUS, 32'h1);
    seq(4'h6);
    chk(load, 32'h1);
    acc(mio_pkg::REG_PROG, 32'h2, 1'b1);
    rd(mio_pkg::REG_OUT, 32'h2);
    seq(4'h7);
    chk(load, 32'h1);
    acc(mio_pkg::REG_PROG, 32'h1, 1'b1);
    seq(4'h8);
    chk(run, 32'h0);
    sw(4'h2);
    @(posedge clk_sys_i);
    mvp <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk(pa, 32'h0);
    rd(mio_pkg::REG_STATUS, 32'h2);
    $display("test sequencer done");
    print_verdict();
  end
endmodule : test_motion_io_port_logic
